// [rtl/volume_automute.sv]
// stereo digital volume with zero-run auto-mute and its control registers
`timescale 1ns/1ns
module volume_automute
	import volume_pkg::*;
(
	input wire logic mclk,
	input wire logic rst,
	input wire logic ce,
	input wire reg_req_t reg_req,
	output logic [7:0] reg_rdata,
	input wire logic sample_valid,
	input wire stereo_t sample_in,
	output logic out_valid,
	output stereo_t sample_out,
	output logic left_auto_muted,
	output logic right_auto_muted
);
	logic [7:0] auto_mute_time_reg, auto_mute_time_next;
	logic [7:0] volume_link_control_reg, volume_link_control_next;
	logic [7:0] left_volume_reg, left_volume_next;
	logic [7:0] right_volume_reg, right_volume_next;
	logic [7:0] rdata_reg, rdata_next;
	logic [RUN_W-1:0] run_reg [2];
	logic [RUN_W-1:0] run_next [2];
	logic muted_reg [2];
	logic muted_next [2];
	logic valid_reg, valid_next;
	stereo_t out_reg, out_next;
	logic [CODE_W-1:0] eff_code [2];
	logic [RUN_FIELD_W-1:0] run_sel [2];
	logic signed [SAMPLE_W-1:0] ch_in [2];
	logic signed [SAMPLE_W-1:0] ch_scaled [2];
	logic [1:0] volume_link_select;
	logic take;

	assign take = ce && sample_valid;
	assign volume_link_select = volume_link_control_reg[LINK_LSB +: LINK_W];
	assign run_sel[0] = auto_mute_time_reg[LEFT_RUN_LSB +: RUN_FIELD_W];
	assign run_sel[1] = auto_mute_time_reg[RIGHT_RUN_LSB +: RUN_FIELD_W];
	assign ch_in[0] = sample_in.left;
	assign ch_in[1] = sample_in.right;

	// gain code per channel, right follows left when linked
	always_comb begin
		eff_code[0] = left_volume_reg;
		eff_code[1] = right_volume_reg; // independent
		if (volume_link_select == LINK_FOLLOW_LEFT) begin
			eff_code[1] = left_volume_reg; // right follows left
		end
	end

	// register writes and registered read data
	always_comb begin
		auto_mute_time_next = auto_mute_time_reg;
		volume_link_control_next = volume_link_control_reg;
		left_volume_next = left_volume_reg;
		right_volume_next = right_volume_reg;
		rdata_next = rdata_reg;
		if (reg_req.wr) begin
			unique case (reg_req.addr)
				AUTO_MUTE_TIME_OFS: auto_mute_time_next = reg_req.wdata;
				VOLUME_LINK_CONTROL_OFS: volume_link_control_next = reg_req.wdata;
				LEFT_VOLUME_OFS: left_volume_next = reg_req.wdata;
				RIGHT_VOLUME_OFS: right_volume_next = reg_req.wdata;
				default: ;
			endcase
		end
		if (reg_req.rd) begin
			unique case (reg_req.addr)
				AUTO_MUTE_TIME_OFS: rdata_next = auto_mute_time_reg;
				VOLUME_LINK_CONTROL_OFS: rdata_next = volume_link_control_reg;
				LEFT_VOLUME_OFS: rdata_next = left_volume_reg;
				RIGHT_VOLUME_OFS: rdata_next = right_volume_reg;
				default: rdata_next = 8'h00;
			endcase
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			auto_mute_time_reg <= AUTO_MUTE_TIME_RST;
			volume_link_control_reg <= VOLUME_LINK_CONTROL_RST;
			left_volume_reg <= LEFT_VOLUME_RST;
			right_volume_reg <= RIGHT_VOLUME_RST;
			rdata_reg <= 8'h00;
		end else if (ce) begin
			auto_mute_time_reg <= auto_mute_time_next;
			volume_link_control_reg <= volume_link_control_next;
			left_volume_reg <= left_volume_next;
			right_volume_reg <= right_volume_next;
			rdata_reg <= rdata_next;
		end
	end

	// per-channel scaler, zero-run counter and mute decision
	genvar g;
	generate
		for (g = 0; g < 2; g++) begin : g_ch
			gain_scaler #(
				.W(SAMPLE_W)
			) u_scale (
				.sample_in(ch_in[g]),
				.gain_code(eff_code[g]),
				.sample_out(ch_scaled[g])
			);

			always_comb begin
				run_next[g] = run_reg[g];
				muted_next[g] = muted_reg[g];
				if (take) begin // counted per sample only
					if (ch_in[g] != '0) begin
						run_next[g] = '0; // restart and release
						muted_next[g] = 1'b0;
					end else begin
						if (run_reg[g] != '1) begin
							run_next[g] = run_reg[g] + 1'b1;
						end
						muted_next[g] = run_next[g] >= RUN_SAMPLES[run_sel[g]];
					end
				end
			end

			always_ff @(posedge mclk or posedge rst) begin
				if (rst) begin
					run_reg[g] <= '0;
					muted_reg[g] <= 1'b0;
				end else if (ce) begin
					run_reg[g] <= run_next[g];
					muted_reg[g] <= muted_next[g];
				end
			end
		end
	endgenerate

	// output sample register, auto-muted channels forced to zero
	always_comb begin
		valid_next = take;
		out_next = out_reg;
		if (take) begin
			out_next.left = muted_next[0] ? '0 : ch_scaled[0];
			out_next.right = muted_next[1] ? '0 : ch_scaled[1];
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			valid_reg <= 1'b0;
			out_reg <= '0;
		end else if (ce) begin
			valid_reg <= valid_next;
			out_reg <= out_next;
		end
	end

	assign reg_rdata = rdata_reg;
	assign out_valid = valid_reg;
	assign sample_out = out_reg;
	assign left_auto_muted = muted_reg[0];
	assign right_auto_muted = muted_reg[1];

	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);

	left_run_mute_a: assert property (take && sample_in.left == '0 && run_reg[0] + 1'b1 >=
		RUN_SAMPLES[run_sel[0]] |=> left_auto_muted && sample_out.left == '0)
		else $error("left channel not auto-muted after zero run");
	right_run_mute_a: assert property (take && sample_in.right == '0 && !right_auto_muted
		&& run_reg[1] + 1'b1 < RUN_SAMPLES[run_sel[1]] |=> !right_auto_muted)
		else $error("right channel muted before zero run complete");
	sample_count_a: assert property (!take |=> $stable(run_reg[0]) && $stable(run_reg[1]))
		else $error("zero run moved without a sample");
	link_indep_a: assert property (take && volume_link_select == LINK_INDEPENDENT &&
		right_volume_reg == GAIN_MUTE_CODE |=> sample_out.right == '0)
		else $error("independent right mute code ignored");
	link_follow_a: assert property (take && volume_link_select == LINK_FOLLOW_LEFT &&
		left_volume_reg == GAIN_UNITY_CODE && !muted_next[1]
		|=> sample_out.right == $past(sample_in.right))
		else $error("right does not follow left gain");
	unity_gain_a: assert property (take && left_volume_reg == GAIN_UNITY_CODE && !muted_next[0]
		|=> sample_out.left == $past(sample_in.left))
		else $error("code 0x30 is not unity gain");
	left_code_mute_a: assert property (take && left_volume_reg == GAIN_MUTE_CODE
		|=> sample_out.left == '0)
		else $error("left mute code leaks signal");
	right_code_mute_a: assert property (take && eff_code[1] == GAIN_MUTE_CODE
		|=> sample_out.right == '0)
		else $error("right mute code leaks signal");
	nonzero_release_a: assert property (take && sample_in.left != '0
		|=> run_reg[0] == '0 && !left_auto_muted)
		else $error("nonzero sample did not release left mute");
	// mirror checks for the other channel, plus the output strobe
	left_run_early_a: assert property (take && sample_in.left == '0
		&& !left_auto_muted && run_reg[0] + 1'b1 < RUN_SAMPLES[run_sel[0]]
		|=> !left_auto_muted)
		else $error("left channel muted before zero run complete");
	right_run_done_a: assert property (take && sample_in.right == '0
		&& run_reg[1] + 1'b1 >= RUN_SAMPLES[run_sel[1]]
		|=> right_auto_muted && sample_out.right == '0)
		else $error("right channel not auto-muted after zero run");
	indep_right_a: assert property (take && volume_link_select == LINK_INDEPENDENT &&
		right_volume_reg == GAIN_UNITY_CODE && !muted_next[1]
		|=> sample_out.right == $past(sample_in.right))
		else $error("independent right gain not applied");
	valid_follow_a: assert property (ce |=> out_valid == $past(take))
		else $error("output strobe does not follow taken samples");
	right_release_a: assert property (take && sample_in.right != '0
		|=> run_reg[1] == '0 && !right_auto_muted)
		else $error("nonzero sample did not release right mute");
	left_mute_cover_c: cover property (take ##1 left_auto_muted);
	right_mute_cover_c: cover property (take ##1 right_auto_muted);
	code_mute_cover_c: cover property (take && eff_code[1] == GAIN_MUTE_CODE);
	release_cover_c: cover property (left_auto_muted ##1 !left_auto_muted);
	follow_cover_c: cover property (take && volume_link_select == LINK_FOLLOW_LEFT);
endmodule : volume_automute

// [rtl/volume_pkg.sv]
// shared constants, register map and carrier types for the volume and auto-mute block
package volume_pkg;
	localparam int SAMPLE_W = 24;
	localparam int CODE_W = 8;
	localparam int RUN_W = 19;
	localparam int TIME_CODES = 8;
	// register offsets
	localparam logic [7:0] AUTO_MUTE_TIME_OFS = 8'h3B;
	localparam logic [7:0] VOLUME_LINK_CONTROL_OFS = 8'h3C;
	localparam logic [7:0] LEFT_VOLUME_OFS = 8'h3D;
	localparam logic [7:0] RIGHT_VOLUME_OFS = 8'h3E;
	// reset values
	localparam logic [7:0] AUTO_MUTE_TIME_RST = 8'h00;
	localparam logic [7:0] VOLUME_LINK_CONTROL_RST = 8'h00;
	localparam logic [7:0] LEFT_VOLUME_RST = 8'h10;
	localparam logic [7:0] RIGHT_VOLUME_RST = 8'h30;
	// field positions
	localparam int LEFT_RUN_LSB = 4;
	localparam int RIGHT_RUN_LSB = 0;
	localparam int RUN_FIELD_W = 3;
	localparam int LINK_LSB = 0;
	localparam int LINK_W = 2;
	localparam logic [1:0] LINK_INDEPENDENT = 2'h0;
	localparam logic [1:0] LINK_FOLLOW_LEFT = 2'h1;
	// gain code landmarks
	localparam logic [7:0] GAIN_MUTE_CODE = 8'hFF;
	localparam logic [7:0] GAIN_UNITY_CODE = 8'h30;
	localparam int GAIN_STEPS_PER_SHIFT = 12;
	localparam int GAIN_FRAC_W = 15;
	localparam int GAIN_MAX_SHIFT_UP = 4;
	// zero-run times in microseconds, counted in samples at the reference rate
	localparam longint REF_RATE_HZ = 96000;
	localparam longint RUN_TIME_US [TIME_CODES] = '{
		11500, 53000, 106500, 266500, 535000, 1065000, 2665000, 5330000};
	localparam logic [RUN_W-1:0] RUN_SAMPLES [TIME_CODES] = '{
		RUN_W'(RUN_TIME_US[0] * REF_RATE_HZ / 1000000),
		RUN_W'(RUN_TIME_US[1] * REF_RATE_HZ / 1000000),
		RUN_W'(RUN_TIME_US[2] * REF_RATE_HZ / 1000000),
		RUN_W'(RUN_TIME_US[3] * REF_RATE_HZ / 1000000),
		RUN_W'(RUN_TIME_US[4] * REF_RATE_HZ / 1000000),
		RUN_W'(RUN_TIME_US[5] * REF_RATE_HZ / 1000000),
		RUN_W'(RUN_TIME_US[6] * REF_RATE_HZ / 1000000),
		RUN_W'(RUN_TIME_US[7] * REF_RATE_HZ / 1000000)};
	// one gain octave in 0.5 dB steps, q1.15
	localparam logic [15:0] GAIN_MANT [GAIN_STEPS_PER_SHIFT] = '{
		16'h8000, 16'h78D7, 16'h7215, 16'h6BB3, 16'h65AD, 16'h5FFD,
		16'h5A9E, 16'h558C, 16'h50C3, 16'h4C3F, 16'h47FB, 16'h43F4};
	typedef struct packed {
		logic signed [SAMPLE_W-1:0] left;
		logic signed [SAMPLE_W-1:0] right;
	} stereo_t;
	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} reg_req_t;
endpackage : volume_pkg

// [rtl/gain_scaler.sv]
// one channel of gain: mantissa times sample, shift by octave, saturate, mute code
`timescale 1ns/1ns
module gain_scaler
	import volume_pkg::*;
#(
	parameter int W = SAMPLE_W
) (
	input wire logic signed [W-1:0] sample_in,
	input wire logic [CODE_W-1:0] gain_code,
	output logic signed [W-1:0] sample_out
);
	localparam logic signed [W-1:0] MAX_S = {1'b0, {(W-1){1'b1}}};
	localparam logic signed [W-1:0] MIN_S = {1'b1, {(W-1){1'b0}}};
	logic [4:0] octave;
	logic [3:0] step;
	logic signed [W+16:0] prod;
	logic signed [W+16:0] shifted;

	// split code into octave and step, scale, clamp
	always_comb begin
		octave = 5'(gain_code / 8'(GAIN_STEPS_PER_SHIFT));
		step = 4'(gain_code % 8'(GAIN_STEPS_PER_SHIFT));
		prod = (W+17)'(sample_in) * (W+17)'($signed({1'b0, GAIN_MANT[step]}));
		shifted = prod >>> (GAIN_FRAC_W - GAIN_MAX_SHIFT_UP + int'(octave));
		if (gain_code == GAIN_MUTE_CODE) begin
			sample_out = '0; // full mute
		end else if (shifted > (W+17)'(MAX_S)) begin
			sample_out = MAX_S;
		end else if (shifted < (W+17)'(MIN_S)) begin
			sample_out = MIN_S;
		end else begin
			sample_out = W'(shifted); // 0.5 dB per code step
		end
	end
endmodule : gain_scaler

// [verification/volume_automute_test.sv]
// self-checking bench for the stereo volume and zero-run auto-mute block
`timescale 1ns/1ns
module volume_automute_test;
	import volume_pkg::*;
	logic mclk = 1'b0;
	logic rst = 1'b1;
	logic ce = 1'b1;
	reg_req_t reg_req = '0;
	logic [7:0] reg_rdata;
	logic sample_valid = 1'b0;
	stereo_t sample_in = '0;
	logic out_valid;
	stereo_t sample_out;
	logic left_auto_muted;
	logic right_auto_muted;
	int n_mismatch = 0;
	int n_checks = 0;
	int cycles = 0;
	volume_automute DUT (.mclk(mclk), .rst(rst), .ce(ce), .reg_req(reg_req),
		.reg_rdata(reg_rdata), .sample_valid(sample_valid), .sample_in(sample_in),
		.out_valid(out_valid), .sample_out(sample_out),
		.left_auto_muted(left_auto_muted), .right_auto_muted(right_auto_muted));
	// 50 MHz clock
	initial begin
		forever #10 mclk = ~mclk;
	end
	task automatic stop_test();
		if (n_mismatch == 0 && n_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : stop_test
	// hang guard, whole run needs about 5200 cycles
	always @(posedge mclk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			n_mismatch = n_mismatch + 1;
			stop_test();
		end
	end
	task automatic chk(input string name, input logic [23:0] exp, input logic [23:0] got);
		n_checks++;
		if (exp !== got) begin
			n_mismatch++;
			$display("Error %s expected %h seen %h", name, exp, got);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge mclk);
		reg_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(posedge mclk);
		reg_req <= '0;
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge mclk);
		reg_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
		@(posedge mclk);
		reg_req <= '0;
		@(negedge mclk);
		chk("reg_rdata", exp, reg_rdata);
	endtask : rd
	task automatic smp(input logic [23:0] l, r, el, er);
		@(posedge mclk);
		sample_valid <= 1'b1;
		sample_in <= '{left: l, right: r};
		@(posedge mclk);
		sample_valid <= 1'b0;
		@(negedge mclk);
		chk("out_valid", 24'h1, out_valid);
		chk("left out", el, sample_out.left);
		chk("right out", er, sample_out.right);
	endtask : smp
	task automatic run_zero(input int n);
		@(posedge mclk);
		sample_valid <= 1'b1;
		sample_in <= '0;
		repeat (n) @(posedge mclk);
		sample_valid <= 1'b0;
	endtask : run_zero
	task automatic test_regs();
		chk("out_valid", 24'h0, out_valid);
		rd(AUTO_MUTE_TIME_OFS, AUTO_MUTE_TIME_RST);
		rd(VOLUME_LINK_CONTROL_OFS, VOLUME_LINK_CONTROL_RST);
		rd(LEFT_VOLUME_OFS, LEFT_VOLUME_RST);
		rd(RIGHT_VOLUME_OFS, RIGHT_VOLUME_RST);
		wr(8'h3F, 8'h5A);
		rd(8'h3F, 8'h00);
		for (int i = 0; i < 4; i++) begin
			wr(8'h3B + 8'(i), 8'hA5 ^ 8'(i));
			rd(8'h3B + 8'(i), 8'hA5 ^ 8'(i));
		end
	endtask : test_regs
	task automatic test_gain();
		logic [7:0] code [5] = '{8'h00, 8'h24, 8'h30, 8'h3C, 8'hFF};
		logic [23:0] pos [5] = '{24'h001000, 24'h000200, 24'h000100, 24'h000080, 24'h0};
		logic [23:0] neg [5] = '{24'hFFF000, 24'hFFFE00, 24'hFFFF00, 24'hFFFF80, 24'h0};
		wr(VOLUME_LINK_CONTROL_OFS, 8'h00);
		for (int i = 0; i < 5; i++) begin
			wr(LEFT_VOLUME_OFS, code[i]);
			wr(RIGHT_VOLUME_OFS, code[4 - i]);
			smp(24'h000100, 24'hFFFF00, pos[i], neg[4 - i]);
		end
	endtask : test_gain
	task automatic test_link();
		wr(LEFT_VOLUME_OFS, 8'h3C);
		wr(RIGHT_VOLUME_OFS, 8'h24);
		wr(VOLUME_LINK_CONTROL_OFS, 8'(LINK_FOLLOW_LEFT));
		smp(24'h000100, 24'h000100, 24'h000080, 24'h000080);
		rd(RIGHT_VOLUME_OFS, 8'h24);
		wr(VOLUME_LINK_CONTROL_OFS, 8'(LINK_INDEPENDENT));
		smp(24'h000100, 24'h000100, 24'h000080, 24'h000200);
		// unused link code 10 behaves as independent
		wr(VOLUME_LINK_CONTROL_OFS, 8'h02);
		smp(24'h000100, 24'h000100, 24'h000080, 24'h000200);
	endtask : test_link
	// mid-run reset returns outputs and registers to their reset state
	task automatic test_reset();
		@(posedge mclk);
		rst <= 1'b1;
		@(posedge mclk);
		rst <= 1'b0;
		@(negedge mclk);
		chk("out_valid reset", 24'h0, out_valid);
		chk("right out reset", 24'h0, sample_out.right);
		chk("right mute reset", 24'h0, right_auto_muted);
		rd(LEFT_VOLUME_OFS, LEFT_VOLUME_RST);
		rd(AUTO_MUTE_TIME_OFS, AUTO_MUTE_TIME_RST);
	endtask : test_reset
	task automatic test_freeze();
		@(posedge mclk);
		ce <= 1'b0;
		sample_valid <= 1'b1;
		@(posedge mclk);
		sample_valid <= 1'b0;
		ce <= 1'b1;
		@(negedge mclk);
		chk("out_valid frozen", 24'h0, out_valid);
	endtask : test_freeze
	// left code 0 needs 1104 zeros, right code 1 needs 5088
	task automatic test_mute();
		wr(LEFT_VOLUME_OFS, GAIN_UNITY_CODE);
		wr(RIGHT_VOLUME_OFS, GAIN_UNITY_CODE);
		wr(AUTO_MUTE_TIME_OFS, 8'h01);
		run_zero(1103);
		@(negedge mclk);
		chk("left mute early", 24'h0, left_auto_muted);
		smp(24'h0, 24'h0, 24'h0, 24'h0);
		chk("left mute", 24'h1, left_auto_muted);
		chk("right mute early", 24'h0, right_auto_muted);
		run_zero(3983);
		@(negedge mclk);
		chk("right mute early", 24'h0, right_auto_muted);
		smp(24'h0, 24'h0, 24'h0, 24'h0);
		chk("right mute", 24'h1, right_auto_muted);
		smp(24'h000100, 24'h0, 24'h000100, 24'h0);
		chk("left release", 24'h0, left_auto_muted);
		chk("right held", 24'h1, right_auto_muted);
		smp(24'h0, 24'h000020, 24'h0, 24'h000020);
		chk("left restart", 24'h0, left_auto_muted);
		chk("right release", 24'h0, right_auto_muted);
	endtask : test_mute
	// main sequence
	initial begin
		repeat (5) @(posedge mclk);
		rst <= 1'b0;
		@(negedge mclk);
		test_regs();
		test_gain();
		test_link();
		test_freeze();
		test_mute();
		test_reset();
		stop_test();
	end
endmodule : volume_automute_test
